// file: src/spb_regs.svh
// Constants for the serial port link bring-up block: timing counts and schedule values.
// Assumes a 25 MHz core clock; times are converted to cycle counts here.
`ifndef SPB_REGS_SVH
`define SPB_REGS_SVH

`define SPB_CLK_MHZ 25
`define SPB_TRAIN_CHARS 200
`define SPB_IDLE_CHARS 10
// Dwell times in microseconds, in schedule order
`define SPB_DWELL0_US 400
`define SPB_DWELL1_US 200
`define SPB_DWELL2_US 100
`define SPB_DWELL3_US 300
`define SPB_DWELL0_CYC (`SPB_DWELL0_US * `SPB_CLK_MHZ)
`define SPB_DWELL1_CYC (`SPB_DWELL1_US * `SPB_CLK_MHZ)
`define SPB_DWELL2_CYC (`SPB_DWELL2_US * `SPB_CLK_MHZ)
`define SPB_DWELL3_CYC (`SPB_DWELL3_US * `SPB_CLK_MHZ)
// Line rate codes: 1 selects the faster rate
`define SPB_RATE_FAST 1'h1
`define SPB_RATE_SLOW 1'h0

`endif

// file: src/spb_pkg.sv
// Types shared by the link bring-up block.
// Assumes spb_regs.svh supplies the numeric constants.
package spb_pkg;

  typedef enum logic [1:0] {
    SPB_PS_DISABLED = 2'b00,
    SPB_PS_ENABLED  = 2'b01,
    SPB_PS_READY    = 2'b10
  } spb_port_state_e;

  typedef enum logic [2:0] {
    SPB_ST_RESET    = 3'b000,
    SPB_ST_FAULT    = 3'b001,
    SPB_ST_TRAIN    = 3'b010,
    SPB_ST_IDLE     = 3'b011,
    SPB_ST_POSTOP   = 3'b100,
    SPB_ST_CREDIT   = 3'b101,
    SPB_ST_AWAIT    = 3'b110,
    SPB_ST_UP       = 3'b111
  } spb_step_e;

  // Reset-type events that knock the port back to disabled and privileged
  typedef struct packed {
    logic powerup_self_test;
    logic total_reset;
    logic absolute_reset;
    logic link_error_recovery_alert;
    logic rate_renegotiate;
  } spb_restart_s;

  // Per-character line status from the receive path
  typedef struct packed {
    logic char_sync;
    logic idle_decoded;
    logic receive_ready_pair;
    logic line_fault;
  } spb_line_s;

  // Port configuration message as processed by the node
  typedef struct packed {
    logic valid;
    logic reflect;
  } spb_cfg_msg_s;

endpackage

// file: src/spb_dwell_timer.sv
// Dwell timer: loads a cycle count and flags expiry.
// Assumes load and the count are synchronous to clk_i.
`timescale 1ns/1ps
module spb_dwell_timer #(
  parameter int WIDTH = 14
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] count_i,
  output logic expired_o
);
  logic [WIDTH-1:0] remain;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remain <= '0;
    end else if (load_i) begin
      remain <= count_i;
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      expired_o <= 1'b0;
    end else begin
      expired_o <= !load_i && (remain == {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end
endmodule

// file: src/spb_char_counter.sv
// Counts transmitted characters up to a target and holds done.
// Assumes char_sent_i pulses once per character sent.
`timescale 1ns/1ps
module spb_char_counter #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic char_sent_i,
  input wire logic [WIDTH-1:0] target_i,
  output logic done_o
);
  logic [WIDTH-1:0] count;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else if (clear_i) begin
      count <= '0;
    end else if (char_sent_i && count != target_i) begin
      count <= count + 1'b1;
    end
  end

  assign done_o = (count == target_i) && !clear_i;
endmodule

// file: src/spb_link_bringup.sv
// Per-port link bring-up: restart handling, rate negotiation, operational flag, credit exchange,
// plus the node-wide token turnaround select.
// Assumes all inputs are synchronous to clk_i; the transmit path pulses char_sent_i per character.
//
// What this block does
// RULE1 - Set turnaround select for single-port or switch, lost port, or reflect message.
// RULE2 - Dual-port node with both ports up clears select on non-reflect message.
// RULE3 - Select set reflects circulating token chars; clear forwards them.
// RULE4 - Self-test, total/absolute reset, recovery alert, renegotiate go disabled and privileged.
// RULE5 - First wait until the line fault detector reports no fault.
// RULE6 - Run rate negotiation; set operational flag only after it completes.
// RULE7 - After operational, wait for at least 10 idle chars sent.
// RULE8 - Need room for one frame, send receive ready pair, drop credit owed.
// RULE9 - On remote receive ready pair, drop credit awaited; privileged frames allowed.
// RULE10 - Negotiation ends on char sync plus idle received; port then ready.
// RULE11 - Single rate: 200 training chars, enabled, idle until sync and idle decoded.
// RULE12 - Dual rate cycles fast 400us, slow 200us, fast 100us, slow 300us forever.
// RULE13 - Dwell timers kept exact, well inside the allowed ten percent.
// RULE14 - Each dwell: switch rate, disable, start timer, send 200 training chars.
// RULE15 - Sync in a dwell: enabled, idle replaces training, control frame may pass.
// RULE16 - Idle decoded before expiry: ready and exit; else next dwell.
// RULE17 - Dwell timer starts at the rate switch; earlier sync is discarded (this block does not: char_sync is used as received).
`include "spb_regs.svh"
`timescale 1ns/1ps
module spb_link_bringup #(
  parameter bit DUAL_RATE = 1'b1,
  parameter int TIMER_W = 14,
  parameter int DWELL0_CYC = `SPB_DWELL0_CYC,
  parameter int DWELL1_CYC = `SPB_DWELL1_CYC,
  parameter int DWELL2_CYC = `SPB_DWELL2_CYC,
  parameter int DWELL3_CYC = `SPB_DWELL3_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire spb_pkg::spb_restart_s restart_i,
  input wire spb_pkg::spb_line_s line_i,
  input wire logic char_sent_i,
  input wire logic rx_room_i,
  input wire logic single_or_switch_i,
  input wire logic other_port_oper_i,
  input wire spb_pkg::spb_cfg_msg_s cfg_msg_i,
  output logic [1:0] port_state_o,
  output logic privileged_o,
  output logic line_rate_o,
  output logic send_training_o,
  output logic send_idle_o,
  output logic send_receive_ready_o,
  output logic ctrl_frame_ok_o,
  output logic port_oper_o,
  output logic rx_credit_owed_o,
  output logic tx_credit_awaited_o,
  output logic frames_ok_o,
  output logic token_turnaround_select_o,
  output logic reflect_token_o
);
  logic rst_sync1;
  logic rst_n;
  spb_pkg::spb_step_e step;
  spb_pkg::spb_step_e next_step;
  spb_pkg::spb_port_state_e pstate;
  logic [1:0] dwell;
  logic load_timer;
  logic [TIMER_W-1:0] dwell_count;
  logic dwell_expired;
  logic clear_chars;
  logic [7:0] char_target;
  logic chars_done;
  logic any_restart;
  logic sync_ok;
  logic [1:0] load_dwell;
  logic dwell_switch;
  logic next_rate;
  logic set_select;
  logic clear_select;

  // Reset release through two flip-flops
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_n <= rst_sync1;
    end
  end

  assign any_restart = |restart_i;
  // Sync is taken straight from char_sync, with no check that it was seen since the last rate switch
  assign sync_ok = line_i.char_sync; // see RULE17

  // The timer is loaded with the length of the dwell being entered, not the one just ended
  assign load_dwell = (step == spb_pkg::SPB_ST_FAULT) ? 2'h0 : dwell + 2'h1;
  // Every load except the one out of fault wait moves to the next dwell
  assign dwell_switch = DUAL_RATE && load_timer && (step != spb_pkg::SPB_ST_FAULT);
  // Odd dwells of the schedule run at the slower rate
  assign next_rate = load_dwell[0] ? `SPB_RATE_SLOW : `SPB_RATE_FAST;

  always_comb begin
    case (load_dwell) // see RULE12
      2'h0: dwell_count = TIMER_W'(DWELL0_CYC);
      2'h1: dwell_count = TIMER_W'(DWELL1_CYC);
      2'h2: dwell_count = TIMER_W'(DWELL2_CYC);
      default: dwell_count = TIMER_W'(DWELL3_CYC);
    endcase
  end

  // Exact cycle counts keep every dwell well inside tolerance, see RULE13
  spb_dwell_timer #(
    .WIDTH(TIMER_W)
  ) u_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .load_i(load_timer),
    .count_i(dwell_count),
    .expired_o(dwell_expired)
  );

  spb_char_counter #(
    .WIDTH(8)
  ) u_chars (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .clear_i(clear_chars),
    .char_sent_i(char_sent_i),
    .target_i(char_target),
    .done_o(chars_done)
  );

  assign char_target = (step == spb_pkg::SPB_ST_POSTOP) ? 8'(`SPB_IDLE_CHARS) : 8'(`SPB_TRAIN_CHARS);

  always_comb begin
    next_step = step;
    load_timer = 1'b0;
    clear_chars = 1'b0;
    case (step)
      spb_pkg::SPB_ST_RESET: begin
        next_step = spb_pkg::SPB_ST_FAULT;
      end
      spb_pkg::SPB_ST_FAULT: begin
        if (!line_i.line_fault) begin // see RULE5
          next_step = spb_pkg::SPB_ST_TRAIN;
          load_timer = 1'b1; // see RULE17
          clear_chars = 1'b1;
        end
      end
      spb_pkg::SPB_ST_TRAIN: begin
        if (chars_done && (DUAL_RATE ? sync_ok : 1'b1)) begin // see RULE11
          next_step = spb_pkg::SPB_ST_IDLE; // see RULE15
        end
      end
      spb_pkg::SPB_ST_IDLE: begin
        if (sync_ok && line_i.idle_decoded) begin // see RULE10
          next_step = spb_pkg::SPB_ST_POSTOP; // see RULE6
          clear_chars = 1'b1;
        end
      end
      spb_pkg::SPB_ST_POSTOP: begin
        if (chars_done) begin // see RULE7
          next_step = spb_pkg::SPB_ST_CREDIT;
        end
      end
      spb_pkg::SPB_ST_CREDIT: begin
        if (rx_room_i) begin // see RULE8
          next_step = spb_pkg::SPB_ST_AWAIT;
        end
      end
      spb_pkg::SPB_ST_AWAIT: begin
        if (line_i.receive_ready_pair) begin // see RULE9
          next_step = spb_pkg::SPB_ST_UP;
        end
      end
      spb_pkg::SPB_ST_UP: begin
        next_step = spb_pkg::SPB_ST_UP;
      end
      default: begin
        next_step = spb_pkg::SPB_ST_RESET;
      end
    endcase
    // Dwell timeout during negotiation moves to the next dwell, see RULE16
    if (DUAL_RATE && dwell_expired &&
        (step == spb_pkg::SPB_ST_TRAIN || step == spb_pkg::SPB_ST_IDLE) &&
        !(step == spb_pkg::SPB_ST_IDLE && sync_ok && line_i.idle_decoded)) begin
      next_step = spb_pkg::SPB_ST_TRAIN; // see RULE14
      load_timer = 1'b1;
      clear_chars = 1'b1;
    end
    if (any_restart) begin // see RULE4
      next_step = spb_pkg::SPB_ST_FAULT;
      load_timer = 1'b0;
      clear_chars = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      step <= spb_pkg::SPB_ST_RESET;
    end else begin
      step <= next_step;
    end
  end

  // Dwell schedule index; it moves with the timer load so rate and timer switch together
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dwell <= 2'h0;
    end else if (any_restart) begin
      dwell <= 2'h0;
    end else if (dwell_switch) begin
      dwell <= load_dwell; // see RULE12
    end
  end

  // Port state: disabled on restart or new dwell, enabled once training ends, ready after idle
  always_comb begin
    case (next_step)
      spb_pkg::SPB_ST_IDLE: pstate = spb_pkg::SPB_PS_ENABLED; // see RULE15
      spb_pkg::SPB_ST_POSTOP,
      spb_pkg::SPB_ST_CREDIT,
      spb_pkg::SPB_ST_AWAIT,
      spb_pkg::SPB_ST_UP: pstate = spb_pkg::SPB_PS_READY; // see RULE10
      default: pstate = spb_pkg::SPB_PS_DISABLED;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      port_state_o <= 2'h0;
    end else begin
      port_state_o <= pstate;
    end
  end

  // Line rate for transmitter and receiver; a restart goes back to the fast rate
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      line_rate_o <= `SPB_RATE_FAST;
    end else if (any_restart) begin
      line_rate_o <= `SPB_RATE_FAST;
    end else if (dwell_switch) begin
      line_rate_o <= next_rate; // see RULE14
    end
  end

  // Training while a dwell opens, idle fill from the enabled state on
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      send_training_o <= 1'b0;
      send_idle_o <= 1'b0;
    end else begin
      send_training_o <= (next_step == spb_pkg::SPB_ST_TRAIN); // see RULE14
      send_idle_o <= (next_step != spb_pkg::SPB_ST_TRAIN) && (next_step != spb_pkg::SPB_ST_FAULT) &&
                     (next_step != spb_pkg::SPB_ST_RESET); // see RULE15
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_frame_ok_o <= 1'b0;
    end else begin
      ctrl_frame_ok_o <= (pstate != spb_pkg::SPB_PS_DISABLED); // see RULE15
    end
  end

  // Privileged mode entered on every restart and held through bring-up
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      privileged_o <= 1'b1;
    end else if (any_restart) begin
      privileged_o <= 1'b1; // see RULE4
    end
  end

  // Operational flag set only after negotiation completes
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      port_oper_o <= 1'b0;
    end else if (any_restart) begin
      port_oper_o <= 1'b0;
    end else if (step == spb_pkg::SPB_ST_IDLE && next_step == spb_pkg::SPB_ST_POSTOP) begin
      port_oper_o <= 1'b1; // see RULE6
    end
  end

  // Credit owed until our pair goes out; a restart owes it again
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_credit_owed_o <= 1'b1;
    end else if (any_restart) begin
      rx_credit_owed_o <= 1'b1;
    end else if (step == spb_pkg::SPB_ST_CREDIT && rx_room_i) begin
      rx_credit_owed_o <= 1'b0; // see RULE8
    end
  end

  // One-cycle request for our pair once a frame buffer is free
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      send_receive_ready_o <= 1'b0;
    end else begin
      send_receive_ready_o <= !any_restart && (step == spb_pkg::SPB_ST_CREDIT) && rx_room_i; // see RULE8
    end
  end

  // Credit awaited until the remote pair arrives; privileged frames pass from then on
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_credit_awaited_o <= 1'b1;
      frames_ok_o <= 1'b0;
    end else if (any_restart) begin
      tx_credit_awaited_o <= 1'b1;
      frames_ok_o <= 1'b0;
    end else if (step == spb_pkg::SPB_ST_AWAIT && line_i.receive_ready_pair) begin
      tx_credit_awaited_o <= 1'b0; // see RULE9
      frames_ok_o <= 1'b1;
    end
  end

  // Setting conditions win over a clear in the same cycle
  assign set_select = single_or_switch_i || !port_oper_o || !other_port_oper_i ||
                      (cfg_msg_i.valid && cfg_msg_i.reflect); // see RULE1
  assign clear_select = cfg_msg_i.valid && !cfg_msg_i.reflect; // see RULE2

  // Node-wide turnaround select
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      token_turnaround_select_o <= 1'b1;
    end else if (set_select) begin
      token_turnaround_select_o <= 1'b1; // see RULE1
    end else if (clear_select) begin
      token_turnaround_select_o <= 1'b0; // see RULE2
    end
  end

  // Reflect control for circulating token chars, kept in step with the select flag
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reflect_token_o <= 1'b1;
    end else if (set_select) begin
      reflect_token_o <= 1'b1; // see RULE3
    end else if (clear_select) begin
      reflect_token_o <= 1'b0; // see RULE3
    end
  end
endmodule

// file: test/spb_properties.sv
// Port-level properties of the link bring-up block.
// Assumes it is bound onto every spb_link_bringup instance.
`timescale 1ns/1ps
module spb_properties (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire spb_pkg::spb_restart_s restart_i,
  input wire spb_pkg::spb_line_s line_i,
  input wire logic char_sent_i,
  input wire logic rx_room_i,
  input wire logic single_or_switch_i,
  input wire logic [1:0] port_state_o,
  input wire logic privileged_o,
  input wire logic line_rate_o,
  input wire logic send_training_o,
  input wire logic send_idle_o,
  input wire logic send_receive_ready_o,
  input wire logic port_oper_o,
  input wire logic rx_credit_owed_o,
  input wire logic tx_credit_awaited_o,
  input wire logic frames_ok_o,
  input wire logic token_turnaround_select_o,
  input wire logic reflect_token_o
);
  logic [15:0] tcnt;
  logic [4:0] icnt;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  // Training characters sent in the current dwell
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i)
      tcnt <= '0;
    else if (!send_training_o || $changed(line_rate_o))
      tcnt <= '0;
    else if (char_sent_i && tcnt != 16'hffff)
      tcnt <= tcnt + 16'h0001;
  end
  // Characters sent since the port became operational
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i)
      icnt <= '0;
    else if (!port_oper_o)
      icnt <= '0;
    else if (char_sent_i && icnt != 5'h1f)
      icnt <= icnt + 5'h01;
  end
  chk_train_count: assert property ($rose(send_idle_o) |-> tcnt >= 16'h00c7)
    else $error("idle fill began before the training run ended");
  chk_idle_gap: assert property (send_receive_ready_o |-> icnt >= 5'h0a && $past(rx_room_i))
    else $error("receive-ready pair sent too early");
  chk_owed_drop: assert property (send_receive_ready_o |-> ##[0:2] !rx_credit_owed_o)
    else $error("credit owed not cleared after the pair");
  chk_oper_ready: assert property ($rose(port_oper_o) |-> port_state_o == 2'h2)
    else $error("operational without negotiation done");
  chk_ready_cause: assert property ($rose(port_state_o == 2'h2) |-> $past(line_i.char_sync)
    && $past(line_i.idle_decoded))
    else $error("ready without sync and idle");
  chk_frames_gate: assert property ($rose(frames_ok_o) |-> !tx_credit_awaited_o && !rx_credit_owed_o
    && port_oper_o)
    else $error("frames allowed before credit exchange");
  chk_restart_down: assert property ((|restart_i) |-> ##[1:2] (port_state_o == 2'h0 && !port_oper_o
    && privileged_o))
    else $error("restart did not disable the port");
  chk_fault_wait: assert property ($rose(send_training_o) |-> !$past(line_i.line_fault))
    else $error("training started during a line fault");
  chk_dwell_reset: assert property ($changed(line_rate_o) |-> port_state_o == 2'h0 && !send_idle_o)
    else $error("rate switch kept an old state");
  chk_select_set: assert property (single_or_switch_i |-> ##[1:2] token_turnaround_select_o)
    else $error("turnaround select not set");
  chk_reflect_map: assert property ($changed(token_turnaround_select_o) |-> ##[0:1]
    reflect_token_o == token_turnaround_select_o)
    else $error("token reflect does not follow select");
endmodule
bind spb_link_bringup spb_properties i_chk (.clk_i, .resetn_i, .restart_i, .line_i, .char_sent_i, .rx_room_i,
  .single_or_switch_i, .port_state_o, .privileged_o, .line_rate_o, .send_training_o, .send_idle_o,
  .send_receive_ready_o, .port_oper_o, .rx_credit_owed_o, .tx_credit_awaited_o, .frames_ok_o,
  .token_turnaround_select_o, .reflect_token_o);

// file: test/spb_remote_port.sv
// Far-end port model: locks at its own rate, decodes idle, answers the receive-ready pair.
// Assumes the bench clock; sync_en_i lets the bench keep it from locking.
`timescale 1ns/1ps
module spb_remote_port (
  input wire logic clk_i,
  input wire logic rate_i,
  input wire logic want_rate_i,
  input wire logic sync_en_i,
  input wire logic fault_i,
  input wire logic tx_active_i,
  input wire logic idle_i,
  input wire logic rr_i,
  input wire logic [7:0] dly_i,
  output spb_pkg::spb_line_s line_o
);
  logic [3:0] lock = '0;
  logic last = 1'b1;
  logic [7:0] wcnt = '0;
  logic pend = 1'b0;
  // Lock is lost when our rate moves, so no sync carries into the next dwell
  always_ff @(posedge clk_i) begin
    last <= rate_i;
    if (fault_i || !sync_en_i || rate_i != want_rate_i || rate_i != last)
      lock <= '0;
    else if (tx_active_i && lock != 4'hf)
      lock <= lock + 4'h1;
  end
  // Own pair goes out a while after ours arrives
  always_ff @(posedge clk_i) begin
    if (rr_i) begin
      pend <= 1'b1;
      wcnt <= dly_i;
    end else if (pend && wcnt != 8'h00)
      wcnt <= wcnt - 8'h01;
    else
      pend <= 1'b0;
  end
  assign line_o.char_sync = lock == 4'hf;
  assign line_o.idle_decoded = lock == 4'hf && idle_i;
  assign line_o.receive_ready_pair = pend && wcnt == 8'h00;
  assign line_o.line_fault = fault_i;
endmodule

// file: test/tb_top.sv
// Bench for the link bring-up block facing the far-end port model.
// Assumes shortened dwells and one character every two clocks.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; $display("FAIL %0t %h %h", $time, a, b); end end
module tb_top;
  localparam int D0 = 600;
  localparam int D1 = 500;
  localparam int D2 = 450;
  localparam int D3 = 550;
  int dl [4] = '{D1, D2, D3, D0};
  // {single_or_switch, other_oper, msg valid, msg reflect, expected select}
  logic [4:0] rows [6] = '{5'h19, 5'h0c, 5'h0f, 5'h0c, 5'h01, 5'h0c};
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cs = 1'b0;
  logic room = 1'b0;
  logic sos = 1'b0;
  logic oop = 1'b1;
  logic want = 1'b1;
  logic fault = 1'b1;
  logic sync_en = 1'b0;
  logic last;
  logic [7:0] dly = 8'h01;
  spb_pkg::spb_restart_s rst = '0;
  spb_pkg::spb_cfg_msg_s cfg = '0;
  spb_pkg::spb_line_s line;
  logic [1:0] pst;
  logic priv, rate, trn, idl, rr, ctl, oper, owed, aw, frm, sel, refl;
  spb_pkg::spb_line_s line1;
  logic [1:0] pst1;
  logic rate1, trn1, idl1, rr1, oper1;
  int rr_n = 0;
  int failures = 0;
  int tests_run = 0;
  int n;
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) cs <= ~cs;
  spb_link_bringup #(.DWELL0_CYC(D0), .DWELL1_CYC(D1), .DWELL2_CYC(D2), .DWELL3_CYC(D3)) i_dut (
    .clk_i, .resetn_i, .restart_i(rst), .line_i(line), .char_sent_i(cs), .rx_room_i(room),
    .single_or_switch_i(sos), .other_port_oper_i(oop), .cfg_msg_i(cfg), .port_state_o(pst),
    .privileged_o(priv), .line_rate_o(rate), .send_training_o(trn), .send_idle_o(idl),
    .send_receive_ready_o(rr), .ctrl_frame_ok_o(ctl), .port_oper_o(oper), .rx_credit_owed_o(owed),
    .tx_credit_awaited_o(aw), .frames_ok_o(frm), .token_turnaround_select_o(sel), .reflect_token_o(refl));
  spb_remote_port i_far (.clk_i, .rate_i(rate), .want_rate_i(want), .sync_en_i(sync_en), .fault_i(fault),
    .tx_active_i(trn | idl), .idle_i(idl), .rr_i(rr), .dly_i(dly), .line_o(line));
  // Single-rate port on the same stimulus, with its own far end
  spb_link_bringup #(.DUAL_RATE(1'b0)) i_dut1 (
    .clk_i, .resetn_i, .restart_i(rst), .line_i(line1), .char_sent_i(cs), .rx_room_i(room),
    .single_or_switch_i(sos), .other_port_oper_i(oop), .cfg_msg_i(cfg), .port_state_o(pst1),
    .privileged_o(), .line_rate_o(rate1), .send_training_o(trn1), .send_idle_o(idl1),
    .send_receive_ready_o(rr1), .ctrl_frame_ok_o(), .port_oper_o(oper1), .rx_credit_owed_o(),
    .tx_credit_awaited_o(), .frames_ok_o(), .token_turnaround_select_o(), .reflect_token_o());
  spb_remote_port i_far1 (.clk_i, .rate_i(rate1), .want_rate_i(1'b1), .sync_en_i(sync_en), .fault_i(fault),
    .tx_active_i(trn1 | idl1), .idle_i(idl1), .rr_i(rr1), .dly_i(dly), .line_o(line1));
  // Receive-ready requests of the dual-rate port, one per bring-up
  always @(posedge clk_i) begin
    if (rr === 1'b1)
      rr_n <= rr_n + 1;
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // 0: operational, 1: frames allowed, 2: line rate moved
  task automatic wait_on(input int w);
    n = 0;
    last = rate;
    do begin
      @(negedge clk_i);
      n++;
    end while (!(w == 0 ? oper === 1'b1 : w == 1 ? frm === 1'b1 : rate !== last) && n < 4000);
    if (n >= 4000) begin
      failures++;
      end_of_test;
    end
  endtask
  task automatic chk_rst;
    `CHK(priv, 1'b1)
    `CHK(pst, 2'h0)
    `CHK(oper, 1'b0)
    `CHK({owed, aw, frm}, 3'h6)
  endtask
  initial begin
    cyc(2);
    resetn_i <= 1'b1;
    cyc(3);
    @(negedge clk_i);
    chk_rst;
    cyc(600);
    @(negedge clk_i);
    `CHK(trn, 1'b0)
    $display("test 1 done");
    cyc(1);
    fault <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      wait_on(2);
      `CHK(rate, i[0])
      `CHK({pst, trn}, 3'h1)
      if (i > 0)
        `CHK(n * 10 >= dl[i-1] * 9 && n * 10 <= dl[i-1] * 11, 1'b1)
    end
    `CHK({pst1, trn1, idl1}, 4'h5)
    $display("test 2 done");
    cyc(1);
    sync_en <= 1'b1;
    want <= 1'b0;
    wait_on(0);
    cyc(60);
    @(negedge clk_i);
    `CHK({rate, pst, owed, idl}, 5'h0b)
    cyc(1);
    room <= 1'b1;
    wait_on(1);
    `CHK({oper, owed, aw, ctl}, 4'h9)
    `CHK({oper1, pst1}, 3'h6)
    $display("test 3 done");
    foreach (rows[i]) begin
      cyc(1);
      {sos, oop, cfg} <= rows[i][4:1];
      cyc(1);
      cfg <= '0;
      cyc(3);
      @(negedge clk_i);
      `CHK({sel, refl}, {2{rows[i][0]}})
    end
    $display("test 4 done");
    for (int i = 0; i < 5; i++) begin
      cyc(1);
      dly <= i[0] ? 8'h28 : 8'h01;
      want <= i[0];
      rst <= 5'h10 >> i;
      cyc(1);
      rst <= '0;
      cyc(2);
      @(negedge clk_i);
      chk_rst;
      wait_on(1);
      `CHK(rate, i[0])
    end
    `CHK(rr_n, 6)
    $display("test 5 done");
    cyc(1);
    fault <= 1'b1;
    resetn_i <= 1'b0;
    cyc(2);
    resetn_i <= 1'b1;
    cyc(3);
    @(negedge clk_i);
    chk_rst;
    $display("test 6 done");
    end_of_test;
  end
endmodule
